// file: inc/qst_pkg.sv
// Purpose: constants shared by the quadrature/step timer
// Assumes: registers are 8 bits wide, one per aligned 32-bit Wishbone word
// Notes: register indices are multiplied by four to form byte addresses
package qst_pkg;
	// register indices
	localparam logic [7:0] REG_CTRL0 = 8'ha1;
	localparam logic [7:0] REG_CTRL1 = 8'ha9;
	localparam logic [7:0] REG_CNT_LO = 8'haa;
	localparam logic [7:0] REG_CNT_HI = 8'hab;
	localparam logic [7:0] REG_DAT_LO = 8'hac;
	localparam logic [7:0] REG_DAT_HI = 8'had;
	localparam logic [7:0] REG_PER_LO = 8'hae;
	localparam logic [7:0] REG_PER_HI = 8'haf;
	localparam logic [7:0] REG_STATUS = 8'hb0;
	localparam int ADDR_SHIFT = 2;
	// control 0 fields
	localparam int PSC_HI = 7;
	localparam int PSC_LO = 5;
	localparam int POL_BIT = 4;
	localparam int MIRQ_BIT = 3;
	localparam int EDGE_BIT = 2;
	localparam int MODE_HI = 1;
	localparam int MODE_LO = 0;
	// control 1 fields
	localparam int STYLE_BIT = 5;
	localparam int EIRQ_BIT = 4;
	localparam int OIRQ_BIT = 3;
	localparam int FILT_BIT = 2;
	localparam int DIR_BIT = 1;
	localparam int EN_BIT = 0;
	// status fields, written 1 to clear
	localparam int ST_MATCH = 0;
	localparam int ST_EDGE = 1;
	localparam int ST_OVF = 2;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam int FILTER_CYCLES = 4;
	typedef enum logic [1:0] {
		QST_CAPTURE = 2'b00,
		QST_OUTPUT = 2'b01,
		QST_COUNT = 2'b10,
		QST_POSITION = 2'b11
	} qst_mode_t;
endpackage

// file: rtl/qst_filter.sv
// Purpose: optional glitch filter for one timer input
// Assumes: input already synchronous to mclk
// Notes: when enabled the output follows a level stable for STABLE cycles
`timescale 1ns/1ps
module qst_filter #(
	parameter int STABLE = qst_pkg::FILTER_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic din,
	output logic dout
);
	logic [STABLE-1:0] hist;
	initial begin
		if (STABLE < 2) $error("qst_filter: STABLE must be at least 2");
	end
	// shift history; output moves when all samples agree
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hist <= '0;
			dout <= 1'b0;
		end else begin
			hist <= {hist[STABLE-2:0], din};
			if (!enable)
				dout <= din;
			else if (&hist)
				dout <= 1'b1; // RL18
			else if (~|hist)
				dout <= 1'b0; // RL24
		end
	end
endmodule

// file: rtl/qst_timer.sv
// Purpose: 16-bit multi-mode timer with quadrature and step decoding
// Assumes: classic Wishbone slave, 8-bit registers in low lanes
// Notes: single-cycle ack; unmapped addresses read zero
`timescale 1ns/1ps
// How it works
// RL1 - encoder uses pins, rotating-state uses comparators
// RL2 - position counts up forward, down reverse
// RL3 - encoder count wraps at programmed encoder value
// RL4 - zero index sets match flag
// RL5 - active edge captures, clears base, flags
// RL6 - base timer overflow at 0xffff flags
// RL7 - step mode: direction pin plus pulse pin
// RL8 - direction updates only on pulse after change
// RL9 - step mode position wraps freely
// RL10 - counter reads base or position by mode
// RL11 - prescale divides clock by two to field
// RL12 - polarity bit meaning depends on mode
// RL13 - match enable gates match interrupt
// RL14 - edge bit: capture edges, active edge, index clear
// RL15 - mode field selects operating mode
// RL16 - step style bit accepts only zero
// RL17 - edge and overflow interrupt enables
// RL18 - filter rejects pulses under four cycles
// RL19 - direction bit readable, derived by mode
// RL20 - enable bit starts and stops base timer
// RL21 - data register meaning by mode
// RL22 - period register meaning by mode
// RL23 - high byte read latches low byte
// RL24 - filtered input lags four cycles
// RL25 - interrupt outputs need flag and enable
module qst_timer #(
	parameter int FILTER_LEN = qst_pkg::FILTER_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pin_a,
	input wire logic pin_b,
	input wire logic index_pin,
	input wire logic comparator_a,
	input wire logic comparator_b,
	output logic timer_out,
	output logic match_irq,
	output logic edge_irq,
	output logic overflow_irq
);
	logic [7:0] ctrl0, ctrl1_w;
	logic direction_flag;
	logic [15:0] base, position_counter, data_register, period_register;
	logic [15:0] data_shadow, next_base;
	logic [7:0] cnt_lo_latch, dat_hi_hold;
	logic match_flag, edge_flag, overflow_flag;
	logic [6:0] psc_cnt;
	logic tick, fa, fb, fa_d, fb_d, fz, fz_d, ovf_evt, act_edge;
	logic dir_now, dir_pend, armed, qdir;
	logic [1:0] mode;
	logic req, wr, rd, clr_base;
	logic [7:0] idx, rdata;
	initial begin
		if (FILTER_LEN < 2) $error("qst_timer: FILTER_LEN must be >= 2");
	end
	assign mode = ctrl0[qst_pkg::MODE_HI:qst_pkg::MODE_LO]; // RL15
	function automatic logic is_mode(input logic [1:0] m,
		input qst_pkg::qst_mode_t t);
		is_mode = (m == 2'(t));
	endfunction
	wire pos_mode = is_mode(mode, qst_pkg::QST_POSITION);
	wire step_mode = pos_mode && ctrl0[qst_pkg::POL_BIT]; // RL12
	wire enc_mode = pos_mode && !ctrl0[qst_pkg::POL_BIT];
	wire en = ctrl1_w[qst_pkg::EN_BIT];
	wire filt = ctrl1_w[qst_pkg::FILT_BIT];
	wire rise_sel = ctrl0[qst_pkg::EDGE_BIT];

	// bus decode: single-cycle ack, index is word address
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx = wb_adr_i[qst_pkg::ADDR_SHIFT+7:qst_pkg::ADDR_SHIFT];
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;

	// input path: pins in encoder and step, comparators in rotating-state
	wire rs_sel = enc_mode && ctrl1_w[7];
	wire src_a = rs_sel ? comparator_a : pin_a; // RL1
	wire src_b = rs_sel ? comparator_b : pin_b; // RL1
	qst_filter #(.STABLE(FILTER_LEN)) u_fa (.mclk(mclk), .rstn(rstn),
		.enable(filt), .din(src_a), .dout(fa));
	qst_filter #(.STABLE(FILTER_LEN)) u_fb (.mclk(mclk), .rstn(rstn),
		.enable(filt), .din(src_b), .dout(fb));
	qst_filter #(.STABLE(FILTER_LEN)) u_fz (.mclk(mclk), .rstn(rstn),
		.enable(filt), .din(index_pin), .dout(fz));

	// edge history of filtered inputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fa_d <= 1'b0;
			fb_d <= 1'b0;
			fz_d <= 1'b0;
		end else begin
			fa_d <= fa;
			fb_d <= fb;
			fz_d <= fz;
		end
	end
	wire a_chg = fa ^ fa_d;
	wire b_chg = fb ^ fb_d;
	wire a_act = rise_sel ? (fa && !fa_d) : (!fa && fa_d); // RL7 RL14
	wire index_evt = enc_mode && fz && !fz_d; // RL4

	// quadrature: every edge of a or b alone counts, direction from phase relation
	always_comb begin
		qdir = direction_flag;
		if (a_chg && !b_chg)
			qdir = (fa == fb); // RL19
		else if (b_chg && !a_chg)
			qdir = (fa != fb);
	end
	wire quad_evt = enc_mode && (a_chg ^ b_chg);
	wire step_evt = step_mode && a_act;
	assign act_edge = quad_evt || step_evt;
	wire count_evt = is_mode(mode, qst_pkg::QST_COUNT) && a_act;
	wire next_dir = step_mode ? (dir_pend ? fb : direction_flag) : qdir;

	// step direction: a change of pin b only arms the update
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dir_pend <= 1'b0;
			direction_flag <= 1'b0;
		end else begin
			if (step_evt)
				dir_pend <= 1'b0;
			else if (step_mode && b_chg)
				dir_pend <= 1'b1; // RL8
			if (act_edge)
				direction_flag <= next_dir; // RL8 RL19
		end
	end

	// prescaler: tick every 2**prescale_select cycles
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			psc_cnt <= '0;
		else if (!en)
			psc_cnt <= '0;
		else
			psc_cnt <= psc_cnt + 7'd1;
	end
	wire [2:0] psel = ctrl0[qst_pkg::PSC_HI:qst_pkg::PSC_LO];
	assign tick = en && ((psc_cnt & ((7'd1 << psel) - 7'd1)) == 7'd0); // RL11

	// base timer: counts ticks, cleared by counting edges
	assign ovf_evt = tick && (base == qst_pkg::CNT_MAX); // RL6
	wire cmp_match = is_mode(mode, qst_pkg::QST_OUTPUT) && tick
		&& (base == data_shadow);
	wire out_wrap = is_mode(mode, qst_pkg::QST_OUTPUT) && tick
		&& (base == period_register);
	wire pos_hit = (position_counter + 16'd1) == data_register;
	wire cnt_match = count_evt && pos_hit;
	assign clr_base = act_edge || cnt_match || out_wrap || ovf_evt;
	always_comb begin
		next_base = base;
		if (clr_base)
			next_base = qst_pkg::CNT_ZERO; // RL5
		else if (tick)
			next_base = base + 16'd1; // RL20
	end
	wire cnt_w_hi = wr && idx == qst_pkg::REG_CNT_HI;
	wire cnt_w_lo = wr && idx == qst_pkg::REG_CNT_LO;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			base <= qst_pkg::CNT_ZERO;
		else if (cnt_w_hi && !pos_mode)
			base <= {wb_dat_i[7:0], base[7:0]};
		else if (cnt_w_lo && !pos_mode)
			base <= {base[15:8], wb_dat_i[7:0]};
		else
			base <= next_base;
	end

	// position counter with mode-dependent wrap
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			position_counter <= qst_pkg::CNT_ZERO;
		else if (cnt_w_hi && pos_mode)
			position_counter <= {wb_dat_i[7:0], position_counter[7:0]};
		else if (cnt_w_lo && pos_mode)
			position_counter <= {position_counter[15:8], wb_dat_i[7:0]};
		else if (index_evt && rise_sel)
			position_counter <= qst_pkg::CNT_ZERO; // RL14
		else if (act_edge && !next_dir) begin
			if (enc_mode && position_counter == data_register)
				position_counter <= qst_pkg::CNT_ZERO; // RL3
			else
				position_counter <= position_counter + 16'd1; // RL2 RL9
		end else if (act_edge) begin
			if (enc_mode && position_counter == qst_pkg::CNT_ZERO)
				position_counter <= data_register; // RL3
			else
				position_counter <= position_counter - 16'd1; // RL2 RL9
		end else if (cnt_match)
			position_counter <= qst_pkg::CNT_ZERO;
		else if (count_evt)
			position_counter <= position_counter + 16'd1;
	end

	// data register: software value, 0xffff or 0x0000 by input level on capture overflow
	wire dat_w_lo = wr && idx == qst_pkg::REG_DAT_LO;
	wire cap_ovf = is_mode(mode, qst_pkg::QST_CAPTURE) && ovf_evt;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			data_register <= qst_pkg::CNT_ZERO;
			dat_hi_hold <= qst_pkg::RESET_BYTE;
		end else begin
			if (wr && idx == qst_pkg::REG_DAT_HI)
				dat_hi_hold <= wb_dat_i[7:0];
			if (dat_w_lo)
				data_register <= {dat_hi_hold, wb_dat_i[7:0]}; // RL21
			else if (cap_ovf)
				data_register <= (fa ^ ctrl0[qst_pkg::POL_BIT]) ?
					qst_pkg::CNT_MAX : qst_pkg::CNT_ZERO; // RL12
		end
	end

	// shadow compare value loads at period end or when stopped
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			data_shadow <= qst_pkg::CNT_ZERO;
		else if (out_wrap || ovf_evt || !en)
			data_shadow <= data_register;
	end

	// period register: captured base timer on counting edges
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			period_register <= qst_pkg::CNT_ZERO;
		else if (act_edge || cnt_match)
			period_register <= base; // RL5 RL22
		else if (cap_ovf)
			period_register <= qst_pkg::CNT_MAX;
		else if (wr && idx == qst_pkg::REG_PER_HI)
			period_register <= {wb_dat_i[7:0], period_register[7:0]};
		else if (wr && idx == qst_pkg::REG_PER_LO)
			period_register <= {period_register[15:8], wb_dat_i[7:0]};
	end

	// control registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl0 <= qst_pkg::RESET_BYTE;
			ctrl1_w <= qst_pkg::RESET_BYTE;
		end else if (wr && idx == qst_pkg::REG_CTRL0)
			ctrl0 <= wb_dat_i[7:0];
		else if (wr && idx == qst_pkg::REG_CTRL1) begin
			ctrl1_w <= wb_dat_i[7:0];
			ctrl1_w[qst_pkg::STYLE_BIT] <= 1'b0; // RL16
			ctrl1_w[qst_pkg::DIR_BIT] <= 1'b0;
		end
	end

	// flags: set wins over write-1-to-clear
	wire [7:0] clr = (wr && idx == qst_pkg::REG_STATUS) ? wb_dat_i[7:0]
		: 8'h00;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			match_flag <= 1'b0;
			edge_flag <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			if (index_evt || cmp_match)
				match_flag <= 1'b1; // RL4
			else if (clr[qst_pkg::ST_MATCH])
				match_flag <= 1'b0;
			if (act_edge || cnt_match)
				edge_flag <= 1'b1; // RL5
			else if (clr[qst_pkg::ST_EDGE])
				edge_flag <= 1'b0;
			if (ovf_evt)
				overflow_flag <= 1'b1; // RL6
			else if (clr[qst_pkg::ST_OVF])
				overflow_flag <= 1'b0;
		end
	end
	wire mirq_ok = ctrl0[qst_pkg::MIRQ_BIT]
		&& !is_mode(mode, qst_pkg::QST_COUNT); // RL13
	assign match_irq = match_flag && mirq_ok; // RL25
	assign edge_irq = edge_flag && ctrl1_w[qst_pkg::EIRQ_BIT]; // RL17
	assign overflow_irq = overflow_flag && ctrl1_w[qst_pkg::OIRQ_BIT]; // RL17

	// output compare level
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			timer_out <= 1'b0;
		else
			timer_out <= (base >= data_shadow) ^ ctrl0[qst_pkg::POL_BIT]; // RL12
	end

	// read mux; counter source depends on mode
	wire [15:0] cnt_view = pos_mode ? position_counter : base; // RL10
	always_comb begin
		if (idx == qst_pkg::REG_CTRL0)
			rdata = ctrl0;
		else if (idx == qst_pkg::REG_CTRL1)
			rdata = {ctrl1_w[7:2], direction_flag, ctrl1_w[0]};
		else if (idx == qst_pkg::REG_CNT_HI)
			rdata = cnt_view[15:8];
		else if (idx == qst_pkg::REG_CNT_LO)
			rdata = cnt_lo_latch; // RL23
		else if (idx == qst_pkg::REG_DAT_HI)
			rdata = data_register[15:8];
		else if (idx == qst_pkg::REG_DAT_LO)
			rdata = data_register[7:0];
		else if (idx == qst_pkg::REG_PER_HI)
			rdata = period_register[15:8];
		else if (idx == qst_pkg::REG_PER_LO)
			rdata = period_register[7:0];
		else if (idx == qst_pkg::REG_STATUS)
			rdata = {5'h00, overflow_flag, edge_flag, match_flag};
		else
			rdata = 8'h00;
	end

	// ack and registered read data; high read latches low byte
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			cnt_lo_latch <= qst_pkg::RESET_BYTE;
		end else begin
			wb_ack_o <= req;
			if (rd)
				wb_dat_o <= {24'h000000, rdata};
			if (rd && idx == qst_pkg::REG_CNT_HI)
				cnt_lo_latch <= cnt_view[7:0]; // RL23
		end
	end

	property p_edge_capture;
		@(posedge mclk) disable iff (!rstn)
		act_edge |=> base == qst_pkg::CNT_ZERO;
	endproperty
	a_edge_capture: assert property (p_edge_capture) // RL5
		else $error("base not cleared on edge");
	property p_ovf_flag;
		@(posedge mclk) disable iff (!rstn) ovf_evt |=> overflow_flag;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) // RL6
		else $error("overflow flag not set");
	property p_irq;
		@(posedge mclk) disable iff (!rstn)
		edge_irq |-> edge_flag && ctrl1_w[qst_pkg::EIRQ_BIT];
	endproperty
	a_irq: assert property (p_irq) // RL25
		else $error("edge irq without flag and enable");
	property p_period;
		@(posedge mclk) disable iff (!rstn)
		act_edge |=> period_register == $past(base);
	endproperty
	a_period: assert property (p_period) // RL22
		else $error("period not captured");
	property p_stop;
		@(posedge mclk) disable iff (!rstn)
		!en && !clr_base && !wr |=> base == $past(base);
	endproperty
	a_stop: assert property (p_stop) // RL20
		else $error("base moved while stopped");
	property p_style;
		@(posedge mclk) disable iff (!rstn) !ctrl1_w[5];
	endproperty
	a_style: assert property (p_style) // RL16
		else $error("style bit set");
	property p_ack;
		@(posedge mclk) disable iff (!rstn) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) // single-cycle ack
		else $error("ack held two cycles");
	property p_upcount;
		@(posedge mclk) disable iff (!rstn)
		step_evt && !next_dir && !wr |=>
			position_counter == $past(position_counter) + 16'd1;
	endproperty
	a_upcount: assert property (p_upcount) // RL9
		else $error("step up count wrong");
endmodule

// file: test/qst_src.sv
// Purpose: far-side source of encoder, step and index signals
// Assumes: requests come as one-cycle go pulses from the bench
// Notes: busy stays high while a pulse of width cycles is out
`timescale 1ns/1ps
module qst_src (
	input wire logic mclk,
	input wire logic go,
	input wire logic [1:0] op,
	input wire logic [7:0] width,
	input wire logic stepm,
	input wire logic dir_lvl,
	output logic pin_a,
	output logic pin_b,
	output logic index_pin,
	output logic busy
);
	logic [1:0] ph;
	logic [1:0] opl;
	logic [7:0] left;
	initial begin
		ph = 2'h0;
		opl = 2'h0;
		left = 8'h00;
	end
	// op 0/1 steps the gray phase, op 2 step pulse, op 3 index pulse
	always @(posedge mclk) begin
		if (go && op == 2'h0)
			ph <= ph + 2'h1;
		if (go && op == 2'h1)
			ph <= ph - 2'h1;
		if (go)
			opl <= op;
		if (go && op[1])
			left <= width;
		else if (left != 8'h00)
			left <= left - 8'h01;
	end
	// a leads b going forward: 00, 10, 11, 01
	assign busy = (left != 8'h00);
	assign pin_a = stepm ? (busy && opl == 2'h2) : ph[0] ^ ph[1];
	assign pin_b = stepm ? dir_lvl : ph[1];
	assign index_pin = busy && opl == 2'h3;
endmodule

// file: test/tb_qst_timer.sv
// Purpose: self-checking bench for the quadrature/step timer
// Assumes: 20 MHz mclk, registers reached over classic Wishbone
// Notes: comparator inputs tied low, byte lane 0 always selected
`timescale 1ns/1ps
module tb_qst_timer;
	typedef struct {logic [7:0] i; logic [7:0] r; logic [7:0] w; logic [7:0] x;} qst_row_t;
	logic mclk, rstn, cyc, stb, we, ack, go, stepm, dirl, pa, pb, ix, busy;
	logic tout, mirq, eirq, oirq;
	logic [1:0] op;
	logic [7:0] wid, v;
	logic [11:0] adr;
	logic [31:0] wdat, rdat;
	logic [15:0] c;
	int fails, total_checks, n;
	// register, reset value, value written, value read back
	qst_row_t rows [9] = '{'{8'ha1, 8'h00, 8'h00, 8'h00},
		'{8'ha9, 8'h00, 8'h3c, 8'h1c}, '{8'haa, 8'h00, 8'h00, 8'h00},
		'{8'hab, 8'h00, 8'h12, 8'h12}, '{8'hac, 8'h00, 8'h00, 8'h00},
		'{8'hae, 8'h00, 8'h56, 8'h56}, '{8'haf, 8'h00, 8'h78, 8'h78},
		'{8'hb0, 8'h00, 8'h07, 8'h00}, '{8'h90, 8'h00, 8'h55, 8'h00}};
	qst_timer qst_timer_i (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_a(pa),
		.pin_b(pb), .index_pin(ix), .comparator_a(1'h0),
		.comparator_b(1'h0), .timer_out(tout), .match_irq(mirq),
		.edge_irq(eirq), .overflow_irq(oirq));
	qst_src qst_src_i (.mclk(mclk), .go(go), .op(op), .width(wid),
		.stepm(stepm), .dir_lvl(dirl), .pin_a(pa), .pin_b(pb),
		.index_pin(ix), .busy(busy));
	// clock
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle; read byte lands in v
	task automatic wb(input logic [7:0] i, input logic w, input logic [7:0] d);
		int k;
		@(posedge mclk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {2'h0, i, 2'h0};
		wdat <= {24'h0, d};
		k = 0;
		// look at ack mid-cycle, where it has settled
		do begin
			@(negedge mclk);
			k++;
		end while (ack !== 1'h1 && k < 20);
		v = rdat[7:0];
		// release at the rising edge that samples ack high
		@(posedge mclk);
		cyc <= 1'h0;
		stb <= 1'h0;
		if (ack !== 1'h1) begin
			fails++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		wb(i, 1'h1, d);
	endtask
	// high byte first, low byte comes from the latch
	task automatic rd16();
		wb(8'hab, 1'h0, 8'h00);
		c[15:8] = v;
		wb(8'haa, 1'h0, 8'h00);
		c[7:0] = v;
	endtask
	// ask the source for one edge or pulse, then let the filter settle
	task automatic src(input logic [1:0] o, input logic [7:0] w);
		int k;
		@(posedge mclk);
		go <= 1'h1;
		op <= o;
		wid <= w;
		@(posedge mclk);
		go <= 1'h0;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (busy === 1'h1 && k < 50);
		repeat (12) @(posedge mclk);
	endtask
	// main sequence
	initial begin
		{rstn, cyc, stb, we, go, stepm, dirl} = 7'h0;
		{op, wid, adr, wdat, fails, total_checks} = '0;
		repeat (2) @(posedge mclk);
		rstn <= 1'h1;
		foreach (rows[j]) begin
			wb(rows[j].i, 1'h0, 8'h00);
			chk("reset value", {8'h0, rows[j].r}, {8'h0, v});
			wr(rows[j].i, rows[j].w);
			wb(rows[j].i, 1'h0, 8'h00);
			chk("readback", {8'h0, rows[j].x}, {8'h0, v});
		end
		// encoder mode, encoder value 3
		wr(8'ha9, 8'h00);
		wr(8'ha1, 8'h03);
		wr(8'had, 8'h00);
		wr(8'hac, 8'h03);
		wr(8'hab, 8'h00);
		wr(8'haa, 8'h00);
		wr(8'ha9, 8'h11);
		repeat (4) src(2'h0, 8'h01);
		rd16();
		chk("enc up wrap", 16'h0000, c);
		chk("edge irq", 16'h1, {15'h0, eirq});
		src(2'h1, 8'h01);
		rd16();
		chk("enc down reload", 16'h0003, c);
		wb(8'ha9, 1'h0, 8'h00);
		chk("enc dir", 16'h1, {15'h0, v[1]});
		wb(8'hae, 1'h0, 8'h00);
		chk("period captured", 16'h1, {15'h0, v != 8'h00});
		wr(8'hb0, 8'h02);
		chk("edge irq clear", 16'h0, {15'h0, eirq});
		src(2'h3, 8'h04);
		chk("index masked", 16'h0, {15'h0, mirq});
		wr(8'ha1, 8'h0b);
		chk("index flag", 16'h1, {15'h0, mirq});
		wr(8'hb0, 8'h01);
		wr(8'ha1, 8'h0f);
		src(2'h3, 8'h04);
		rd16();
		chk("index clear", 16'h0000, c);
		// step mode, rising edges active
		wr(8'ha9, 8'h00);
		wr(8'ha1, 8'h17);
		stepm <= 1'h1;
		wr(8'hab, 8'hff);
		wr(8'haa, 8'hff);
		wr(8'ha9, 8'h01);
		src(2'h2, 8'h04);
		rd16();
		chk("step up wrap", 16'h0000, c);
		@(posedge mclk);
		dirl <= 1'h1;
		repeat (12) @(posedge mclk);
		wb(8'ha9, 1'h0, 8'h00);
		chk("dir held", 16'h0, {15'h0, v[1]});
		src(2'h2, 8'h04);
		rd16();
		chk("step down wrap", 16'hffff, c);
		wb(8'ha9, 1'h0, 8'h00);
		chk("dir after pulse", 16'h1, {15'h0, v[1]});
		wb(8'hab, 1'h0, 8'h00);
		src(2'h2, 8'h04);
		wb(8'haa, 1'h0, 8'h00);
		chk("latched low", 16'h00ff, {8'h0, v});
		wr(8'ha9, 8'h05);
		src(2'h2, 8'h02);
		rd16();
		chk("glitch dropped", 16'hfffe, c);
		src(2'h2, 8'h08);
		rd16();
		chk("filtered pulse", 16'hfffd, c);
		// base timer overflow in capture mode
		stepm <= 1'h0;
		wr(8'ha9, 8'h00);
		wr(8'ha1, 8'h00);
		wr(8'hab, 8'hff);
		wr(8'haa, 8'hf0);
		wr(8'ha9, 8'h09);
		n = 0;
		while (oirq !== 1'h1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk("overflow irq", 16'h1, {15'h0, oirq});
		wr(8'ha9, 8'h00);
		chk("overflow masked", 16'h0, {15'h0, oirq});
		rd16();
		n = c;
		rd16();
		chk("stopped", n[15:0], c);
		// slowest prescale barely moves in 100 cycles
		wr(8'hab, 8'h00);
		wr(8'haa, 8'h00);
		wr(8'ha1, 8'he0);
		wr(8'ha9, 8'h01);
		repeat (100) @(posedge mclk);
		wr(8'ha9, 8'h00);
		rd16();
		chk("prescale", 16'h1, {15'h0, c <= 16'h0001});
		// output mode compare against 0x0010 with base at 0x0020
		wr(8'ha1, 8'h01);
		wr(8'had, 8'h00);
		wr(8'hac, 8'h10);
		wr(8'hab, 8'h00);
		wr(8'haa, 8'h20);
		repeat (3) @(posedge mclk);
		chk("out above", 16'h1, {15'h0, tout});
		wr(8'ha1, 8'h11);
		repeat (3) @(posedge mclk);
		chk("out inverted", 16'h0, {15'h0, tout});
		// reset in mid-run
		@(posedge mclk);
		rstn <= 1'h0;
		@(posedge mclk);
		rstn <= 1'h1;
		wb(8'ha1, 1'h0, 8'h00);
		chk("ctrl0 after reset", 16'h0, {8'h0, v});
		end_sim();
	end
endmodule
